// file: src/mpse_pkg.sv
// Constants and carrier types for the two-port multiplexed pin block.
// Assumes a 32-bit AXI4-Lite register bus; register index times four gives the byte address.
package mpse_pkg;
	// ------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [7:0] IDX_P7_LATCH = 8'h13;
	localparam logic [7:0] IDX_P7_DIR = 8'h15;
	localparam logic [7:0] IDX_P7_FUNC = 8'h17;
	localparam logic [7:0] IDX_P8_LATCH = 8'h18;
	localparam logic [7:0] IDX_P8_DIR = 8'h1A;
	localparam logic [7:0] IDX_P8_FUNC = 8'h1C;
	localparam logic [7:0] IDX_P8_ODEN = 8'h20;
	localparam logic [7:0] IDX_CLKOUT_CTRL = 8'h21;
	localparam logic [7:0] IDX_ALT_IN_CTRL = 8'h22;
	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] RST_P7_LATCH = 8'hFF;
	localparam logic [7:0] RST_P7_DIR = 8'h00;
	localparam logic [7:0] RST_P7_FUNC = 8'h00;
	localparam logic [7:0] RST_P8_LATCH = 8'hFF;
	localparam logic [7:0] RST_P8_DIR = 8'hC0;
	localparam logic [7:0] RST_P8_FUNC = 8'h00;
	localparam logic [7:0] RST_P8_ODEN = 8'h00;
	localparam logic [1:0] RST_CLKOUT_CTRL = 2'h0;
	localparam logic [7:0] RST_ALT_IN_CTRL = 8'h00;
	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int P7_TMR_A_BIT = 2;
	localparam int P7_CLK_BIT = 3;
	localparam int P7_TMR_B_BIT = 6;
	localparam int P7_NMI_BIT = 7;
	localparam int P8_TXD_BIT = 0;
	localparam int P8_RXD_BIT = 1;
	localparam int P8_TEVT_BIT = 2;
	localparam int P8_TOUT_BIT = 3;
	localparam int P8_WAIT_BIT = 4;
	localparam logic [7:0] P8_FUNC_MASK = 8'h09;
	localparam logic [7:0] P8_ODEN_MASK = 8'h3F;
	localparam logic [7:0] P8_FIXED_OD = 8'hC0;
	localparam int CKO_EN_BIT = 0;
	localparam int CKO_SEL_BIT = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] level;
		logic [7:0] drive_en;
	} mpse_pins_s;
	typedef struct packed {
		logic [3:0] irq_edge;
		logic [3:0] timer_event;
	} mpse_events_s;
endpackage : mpse_pkg

// file: src/mpse_port78.sv
// Pin logic, alternate-function routing and AXI4-Lite registers for ports seven and eight.
// Assumes peripheral signals are on CLOCK; pin inputs are asynchronous and synchronised here.
`timescale 1ns/1ps
module mpse_port78 (
	input wire logic CLOCK,
	input wire logic NRST,
	input wire logic [9:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [9:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [7:0] P7_PIN_IN,
	output mpse_pkg::mpse_pins_s P7_PIN_OUT,
	output logic [7:0] P7_PULLUP_EN,
	input wire logic [7:0] P8_PIN_IN,
	output mpse_pkg::mpse_pins_s P8_PIN_OUT,
	input wire logic SERIAL_ZERO_RX_PIN,
	output logic SERIAL_ZERO_RECEIVE,
	output logic SERIAL_ONE_RECEIVE,
	output logic BYTE_TIMER_EVENT_INPUT,
	output logic BUS_WAIT_REQ_N,
	output logic NMI_INPUT_N,
	output mpse_pkg::mpse_events_s SHARED_EVENTS,
	input wire logic TIMER_FLIPFLOP_OUTPUT_A,
	input wire logic TIMER_FLIPFLOP_OUTPUT_B,
	input wire logic SERIAL_ONE_TRANSMIT,
	input wire logic BYTE_TIMER_OUTPUT,
	input wire logic PRESCALER_CLOCK,
	input wire logic SYSTEM_CLOCK_SOURCE
);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] read_mix(input logic [7:0] dir, input logic [7:0] latch,
		input logic [7:0] pin);
		read_mix = (dir & latch) | (~dir & pin);
	endfunction : read_mix
	function automatic logic [3:0] shared_bits(input logic [7:0] v);
		shared_bits = {v[5], v[4], v[1], v[0]};
	endfunction : shared_bits
	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic [7:0] p7_latch_r;
	logic [7:0] p7_dir_r;
	logic [7:0] p7_func_r;
	logic nmi_sel_r;
	logic [7:0] p8_latch_r;
	logic [7:0] p8_dir_r;
	logic [7:0] p8_func_r;
	logic [7:0] p8_oden_r;
	logic [1:0] cko_ctrl_r;
	logic [7:0] alt_in_r;
	// Pin synchronisers start at the pulled-up idle level, so no false edge follows reset.
	logic [7:0] p7_s1_r;
	logic [7:0] p7_s2_r;
	logic [7:0] p7_prev_r;
	logic [7:0] p8_s1_r;
	logic [7:0] p8_s2_r;
	logic rx0_s1_r;
	logic rx0_s2_r;
	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
		begin
			p7_s1_r <= 8'hFF;
			p7_s2_r <= 8'hFF;
			p7_prev_r <= 8'hFF;
			p8_s1_r <= 8'hFF;
			p8_s2_r <= 8'hFF;
			rx0_s1_r <= 1'b1;
			rx0_s2_r <= 1'b1;
		end
		else
		begin
			p7_s1_r <= P7_PIN_IN;
			p7_s2_r <= p7_s1_r;
			p7_prev_r <= p7_s2_r;
			p8_s1_r <= P8_PIN_IN;
			p8_s2_r <= p8_s1_r;
			rx0_s1_r <= SERIAL_ZERO_RX_PIN;
			rx0_s2_r <= rx0_s1_r;
		end
	end
	// ------------------------------------------------------------
	// AXI4-Lite write path
	// ------------------------------------------------------------
	logic aw_full_r;
	logic w_full_r;
	logic [7:0] aw_idx_r;
	logic [7:0] w_byte_r;
	logic w_lane_r;
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	wire aw_take = S_AXI_AWVALID & awready_r;
	wire w_take = S_AXI_WVALID & wready_r;
	wire do_write = aw_full_r & w_full_r & ~bvalid_r;
	wire aw_full_nxt = (aw_full_r | aw_take) & ~do_write;
	wire w_full_nxt = (w_full_r | w_take) & ~do_write;
	wire bvalid_nxt = do_write | (bvalid_r & ~S_AXI_BREADY);
	wire wr_ok = w_lane_r;
	wire wr_p7_latch = do_write & wr_ok & (aw_idx_r == mpse_pkg::IDX_P7_LATCH);
	wire wr_p7_dir = do_write & wr_ok & (aw_idx_r == mpse_pkg::IDX_P7_DIR);
	wire wr_p7_func = do_write & wr_ok & (aw_idx_r == mpse_pkg::IDX_P7_FUNC);
	wire wr_p8_latch = do_write & wr_ok & (aw_idx_r == mpse_pkg::IDX_P8_LATCH);
	wire wr_p8_dir = do_write & wr_ok & (aw_idx_r == mpse_pkg::IDX_P8_DIR);
	wire wr_p8_func = do_write & wr_ok & (aw_idx_r == mpse_pkg::IDX_P8_FUNC);
	wire wr_p8_oden = do_write & wr_ok & (aw_idx_r == mpse_pkg::IDX_P8_ODEN);
	wire wr_cko = do_write & wr_ok & (aw_idx_r == mpse_pkg::IDX_CLKOUT_CTRL);
	wire wr_alt = do_write & wr_ok & (aw_idx_r == mpse_pkg::IDX_ALT_IN_CTRL);
	wire wr_hit = wr_p7_latch | wr_p7_dir | wr_p7_func | wr_p8_latch | wr_p8_dir | wr_p8_func
		| wr_p8_oden | wr_cko | wr_alt;
	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
		begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			aw_idx_r <= 8'h00;
			w_byte_r <= 8'h00;
			w_lane_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= mpse_pkg::RESP_OKAY;
		end
		else
		begin
			aw_full_r <= aw_full_nxt;
			w_full_r <= w_full_nxt;
			if (aw_take)
				aw_idx_r <= S_AXI_AWADDR[9:2];
			if (w_take)
			begin
				w_byte_r <= S_AXI_WDATA[7:0];
				w_lane_r <= S_AXI_WSTRB[0];
			end
			awready_r <= ~aw_full_nxt;
			wready_r <= ~w_full_nxt;
			bvalid_r <= bvalid_nxt;
			if (do_write)
				bresp_r <= (wr_hit | ~wr_ok) ? mpse_pkg::RESP_OKAY : mpse_pkg::RESP_SLVERR;
		end
	end
	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	// The selection bit can only be set; a zero written later is dropped on purpose.
	wire nmi_sel_nxt = nmi_sel_r | (wr_p7_func & w_byte_r[mpse_pkg::P7_NMI_BIT]);
	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
		begin
			p7_latch_r <= mpse_pkg::RST_P7_LATCH;
			p7_dir_r <= mpse_pkg::RST_P7_DIR;
			p7_func_r <= mpse_pkg::RST_P7_FUNC;
			nmi_sel_r <= 1'b0;
			p8_latch_r <= mpse_pkg::RST_P8_LATCH;
			p8_dir_r <= mpse_pkg::RST_P8_DIR;
			p8_func_r <= mpse_pkg::RST_P8_FUNC;
			p8_oden_r <= mpse_pkg::RST_P8_ODEN;
			cko_ctrl_r <= mpse_pkg::RST_CLKOUT_CTRL;
			alt_in_r <= mpse_pkg::RST_ALT_IN_CTRL;
		end
		else
		begin
			if (wr_p7_latch)
				p7_latch_r <= w_byte_r;
			if (wr_p7_dir)
				p7_dir_r <= w_byte_r;
			if (wr_p7_func)
				p7_func_r <= w_byte_r;
			nmi_sel_r <= nmi_sel_nxt;
			if (wr_p8_latch)
				p8_latch_r <= w_byte_r;
			if (wr_p8_dir)
				p8_dir_r <= w_byte_r;
			if (wr_p8_func)
				p8_func_r <= w_byte_r & mpse_pkg::P8_FUNC_MASK;
			if (wr_p8_oden)
				p8_oden_r <= w_byte_r & mpse_pkg::P8_ODEN_MASK;
			if (wr_cko)
				cko_ctrl_r <= w_byte_r[1:0];
			if (wr_alt)
				alt_in_r <= w_byte_r;
		end
	end
	// ------------------------------------------------------------
	// AXI4-Lite read path
	// ------------------------------------------------------------
	logic arready_r;
	logic rvalid_r;
	logic [7:0] rbyte_r;
	logic [1:0] rresp_r;
	wire ar_take = S_AXI_ARVALID & arready_r;
	wire rvalid_nxt = ar_take | (rvalid_r & ~S_AXI_RREADY);
	wire [7:0] ar_idx = S_AXI_ARADDR[9:2];
	// Direction and function registers are write-only and read back as zero.
	wire rd_wo = (ar_idx == mpse_pkg::IDX_P7_DIR) | (ar_idx == mpse_pkg::IDX_P7_FUNC)
		| (ar_idx == mpse_pkg::IDX_P8_DIR) | (ar_idx == mpse_pkg::IDX_P8_FUNC);
	wire [7:0] rd_p7 = read_mix(p7_dir_r, p7_latch_r, p7_s2_r);
	wire [7:0] rd_p8 = read_mix(p8_dir_r, p8_latch_r, p8_s2_r);
	wire rd_hit = rd_wo | (ar_idx == mpse_pkg::IDX_P7_LATCH) | (ar_idx == mpse_pkg::IDX_P8_LATCH)
		| (ar_idx == mpse_pkg::IDX_P8_ODEN) | (ar_idx == mpse_pkg::IDX_CLKOUT_CTRL)
		| (ar_idx == mpse_pkg::IDX_ALT_IN_CTRL);
	wire [7:0] rd_val = (ar_idx == mpse_pkg::IDX_P7_LATCH) ? rd_p7 :
		(ar_idx == mpse_pkg::IDX_P8_LATCH) ? rd_p8 :
		(ar_idx == mpse_pkg::IDX_P8_ODEN) ? p8_oden_r :
		(ar_idx == mpse_pkg::IDX_CLKOUT_CTRL) ? {6'h00, cko_ctrl_r} :
		(ar_idx == mpse_pkg::IDX_ALT_IN_CTRL) ? alt_in_r : 8'h00;
	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
		begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rbyte_r <= 8'h00;
			rresp_r <= mpse_pkg::RESP_OKAY;
		end
		else
		begin
			arready_r <= ~rvalid_nxt;
			rvalid_r <= rvalid_nxt;
			if (ar_take)
			begin
				rbyte_r <= rd_val;
				rresp_r <= rd_hit ? mpse_pkg::RESP_OKAY : mpse_pkg::RESP_SLVERR;
			end
		end
	end
	// ------------------------------------------------------------
	// Pin drive and alternate functions
	// ------------------------------------------------------------
	wire cko_active = p7_dir_r[mpse_pkg::P7_CLK_BIT] & cko_ctrl_r[mpse_pkg::CKO_EN_BIT];
	wire cko_src = cko_ctrl_r[mpse_pkg::CKO_SEL_BIT] ? SYSTEM_CLOCK_SOURCE
		: PRESCALER_CLOCK;
	logic [7:0] p7_val;
	always_comb
	begin
		p7_val = p7_latch_r;
		if (p7_func_r[mpse_pkg::P7_TMR_A_BIT])
			p7_val[mpse_pkg::P7_TMR_A_BIT] = TIMER_FLIPFLOP_OUTPUT_A;
		if (p7_func_r[mpse_pkg::P7_TMR_B_BIT])
			p7_val[mpse_pkg::P7_TMR_B_BIT] = TIMER_FLIPFLOP_OUTPUT_B;
		if (cko_active)
			p7_val[mpse_pkg::P7_CLK_BIT] = cko_src;
	end
	// The nonmaskable selection forces the top pin off the drive, whatever its direction.
	wire [7:0] p7_oe = p7_dir_r & ~{nmi_sel_r, 7'h00};
	logic [7:0] p8_val;
	always_comb
	begin
		p8_val = p8_latch_r;
		if (p8_func_r[mpse_pkg::P8_TXD_BIT])
			p8_val[mpse_pkg::P8_TXD_BIT] = SERIAL_ONE_TRANSMIT;
		if (p8_func_r[mpse_pkg::P8_TOUT_BIT])
			p8_val[mpse_pkg::P8_TOUT_BIT] = BYTE_TIMER_OUTPUT;
	end
	wire [7:0] p8_od = p8_oden_r | mpse_pkg::P8_FIXED_OD;
	wire [7:0] p8_level = p8_val & ~p8_od;
	wire [7:0] p8_oe = p8_dir_r & ~(p8_od & p8_val);
	// Edge pulses come from the synchronised level, so pin direction does not gate them.
	wire [3:0] p7_edges = shared_bits(p7_s2_r ^ p7_prev_r);
	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
		begin
			P7_PIN_OUT <= '0;
			P7_PULLUP_EN <= mpse_pkg::RST_P7_LATCH & ~mpse_pkg::RST_P7_DIR;
			P8_PIN_OUT <= '0;
			SERIAL_ZERO_RECEIVE <= 1'b1;
			SERIAL_ONE_RECEIVE <= 1'b1;
			BYTE_TIMER_EVENT_INPUT <= 1'b1;
			BUS_WAIT_REQ_N <= 1'b1;
			NMI_INPUT_N <= 1'b1;
			SHARED_EVENTS <= '0;
		end
		else
		begin
			P7_PIN_OUT.level <= p7_val;
			P7_PIN_OUT.drive_en <= p7_oe;
			P7_PULLUP_EN <= ~p7_dir_r & p7_latch_r;
			P8_PIN_OUT.level <= p8_level;
			P8_PIN_OUT.drive_en <= p8_oe;
			SERIAL_ZERO_RECEIVE <= rx0_s2_r;
			SERIAL_ONE_RECEIVE <= p8_s2_r[mpse_pkg::P8_RXD_BIT];
			BYTE_TIMER_EVENT_INPUT <= p8_s2_r[mpse_pkg::P8_TEVT_BIT];
			BUS_WAIT_REQ_N <= p8_s2_r[mpse_pkg::P8_WAIT_BIT];
			NMI_INPUT_N <= nmi_sel_r ? p7_s2_r[mpse_pkg::P7_NMI_BIT] : 1'b1;
			SHARED_EVENTS.irq_edge <= p7_edges & alt_in_r[3:0];
			SHARED_EVENTS.timer_event <= p7_edges & alt_in_r[7:4];
		end
	end
	assign S_AXI_AWREADY = awready_r;
	assign S_AXI_WREADY = wready_r;
	assign S_AXI_BVALID = bvalid_r;
	assign S_AXI_BRESP = bresp_r;
	assign S_AXI_ARREADY = arready_r;
	assign S_AXI_RVALID = rvalid_r;
	assign S_AXI_RRESP = rresp_r;
	assign S_AXI_RDATA = {24'h000000, rbyte_r};
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_nmi_stays_set: assert property (@(posedge CLOCK) disable iff (!NRST)
		nmi_sel_r |=> nmi_sel_r) else $error("nonmaskable select was cleared");
	a_nmi_no_drive: assert property (@(posedge CLOCK) disable iff (!NRST)
		nmi_sel_r |=> !P7_PIN_OUT.drive_en[7]) else $error("nonmaskable pin is driven");
	a_clock_gated: assert property (@(posedge CLOCK) disable iff (!NRST)
		!cko_active |=> P7_PIN_OUT.level[3] == $past(p7_latch_r[3]))
		else $error("clock output leaked while disabled");
	a_irq_both_edges: assert property (@(posedge CLOCK) disable iff (!NRST)
		(alt_in_r[0] && (p7_s2_r[0] != p7_prev_r[0])) |=> SHARED_EVENTS.irq_edge[0])
		else $error("shared pin edge gave no interrupt pulse");
	a_timer_every_edge: assert property (@(posedge CLOCK) disable iff (!NRST)
		(alt_in_r[6] && (p7_s2_r[4] != p7_prev_r[4])) |=> SHARED_EVENTS.timer_event[2])
		else $error("shared pin edge gave no timer event");
	a_top_pins_od: assert property (@(posedge CLOCK) disable iff (!NRST)
		P8_PIN_OUT.level[7:6] == 2'b00) else $error("port eight top pins driven high");
	a_pullup_follow: assert property (@(posedge CLOCK) disable iff (!NRST)
		##1 P7_PULLUP_EN == ($past(p7_latch_r) & ~$past(p7_dir_r)))
		else $error("pull-up does not follow latch on inputs");
	a_reset_inputs: assert property (@(posedge CLOCK) disable iff (!NRST)
		$past(!NRST) |-> (p7_dir_r == 8'h00 && p7_func_r == 8'h00 && !nmi_sel_r))
		else $error("port seven not cleared by reset");
	a_rxd_route: assert property (@(posedge CLOCK) disable iff (!NRST)
		##1 SERIAL_ZERO_RECEIVE == $past(rx0_s2_r)) else $error("receive pin not routed");
	a_write_answer: assert property (@(posedge CLOCK) disable iff (!NRST)
		do_write |=> S_AXI_BVALID) else $error("write response missing");
	a_bresp_holds: assert property (@(posedge CLOCK) disable iff (!NRST)
		S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID) else $error("write response dropped early");
endmodule : mpse_port78

// file: testbench/mpse_pin_model.sv
// Board-side model of the port seven and port eight pins.
// Assumes the bench sets which external drivers are on; port eight has board pull-ups.
`timescale 1ns/1ps
module mpse_pin_model (
	input wire logic clock,
	input mpse_pkg::mpse_pins_s p7_out,
	input wire logic [7:0] p7_pullup,
	input mpse_pkg::mpse_pins_s p8_out,
	input wire logic [7:0] p7_ext_val,
	input wire logic [7:0] p7_ext_en,
	input wire logic [7:0] p8_ext_val,
	input wire logic [7:0] p8_ext_en,
	output logic [7:0] p7_in,
	output logic [7:0] p8_in
);
	logic [7:0] float_r = 8'h55;
	// A floating line changes every cycle so that a stale value can never pass for a real one.
	always_ff @(posedge clock)
	begin
		float_r <= ~float_r;
	end
	assign p7_in = (p7_out.drive_en & p7_out.level)
		| (~p7_out.drive_en & ((p7_ext_en & p7_ext_val) | (~p7_ext_en & (p7_pullup | float_r))));
	// Open-drain pins only pull low, so the board pull-ups give the high level.
	assign p8_in = (p8_out.drive_en & p8_out.level) | (~p8_out.drive_en & (~p8_ext_en | p8_ext_val));
endmodule : mpse_pin_model

// file: testbench/mpse_port78_tb_top.sv
// Self-checking bench for the port seven and eight pin block.
// Assumes the pin model on the board side and an AXI4-Lite master in this module.
`timescale 1ns/1ps
module mpse_port78_tb_top;
	logic CLOCK = 1'h0, NRST = 1'h0;
	logic [9:0] S_AXI_AWADDR = 10'h0, S_AXI_ARADDR = 10'h0;
	logic S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
	logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0;
	logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
	logic [3:0] S_AXI_WSTRB = 4'h0;
	logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
	logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
	logic [7:0] P7_PIN_IN, P8_PIN_IN, P7_PULLUP_EN;
	mpse_pkg::mpse_pins_s P7_PIN_OUT, P8_PIN_OUT;
	mpse_pkg::mpse_events_s SHARED_EVENTS;
	logic SERIAL_ZERO_RX_PIN = 1'h1, TIMER_FLIPFLOP_OUTPUT_A = 1'h0, TIMER_FLIPFLOP_OUTPUT_B = 1'h0;
	logic SERIAL_ONE_TRANSMIT = 1'h0, BYTE_TIMER_OUTPUT = 1'h1;
	logic PRESCALER_CLOCK = 1'h1, SYSTEM_CLOCK_SOURCE = 1'h0;
	logic SERIAL_ZERO_RECEIVE, SERIAL_ONE_RECEIVE, BYTE_TIMER_EVENT_INPUT, BUS_WAIT_REQ_N;
	logic NMI_INPUT_N;
	logic [7:0] p7_ext_val = 8'h0, p7_ext_en = 8'h0, p8_ext_val = 8'h0, p8_ext_en = 8'h0;
	int checks = 0, num_errors = 0, cycles = 0;

	mpse_port78 DUT (.CLOCK, .NRST, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
		.S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
		.S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
		.S_AXI_RREADY, .P7_PIN_IN, .P7_PIN_OUT, .P7_PULLUP_EN, .P8_PIN_IN, .P8_PIN_OUT,
		.SERIAL_ZERO_RX_PIN, .SERIAL_ZERO_RECEIVE, .SERIAL_ONE_RECEIVE, .BYTE_TIMER_EVENT_INPUT,
		.BUS_WAIT_REQ_N, .NMI_INPUT_N, .SHARED_EVENTS, .TIMER_FLIPFLOP_OUTPUT_A,
		.TIMER_FLIPFLOP_OUTPUT_B, .SERIAL_ONE_TRANSMIT, .BYTE_TIMER_OUTPUT, .PRESCALER_CLOCK,
		.SYSTEM_CLOCK_SOURCE);
	mpse_pin_model board (.clock(CLOCK), .p7_out(P7_PIN_OUT), .p7_pullup(P7_PULLUP_EN),
		.p8_out(P8_PIN_OUT), .p7_ext_val, .p7_ext_en, .p8_ext_val, .p8_ext_en,
		.p7_in(P7_PIN_IN), .p8_in(P8_PIN_IN));

	always #2 CLOCK = ~CLOCK;
	always @(posedge CLOCK)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			conclude();
		end
	end
	// ----------------------------------------
	// Bus cycles and comparisons
	// ----------------------------------------
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_pins(input mpse_pkg::mpse_pins_s g, input logic [15:0] e);
		chk({16'h0, g.level & g.drive_en, g.drive_en}, {16'h0, e[15:8] & e[7:0], e[7:0]});
	endtask : chk_pins
	// Software never reads these registers back to modify them; every write is a whole value.
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic s = 1'h1,
		input logic [1:0] er = mpse_pkg::RESP_OKAY);
		logic ta;
		logic tw;
		ta = 1'h0;
		tw = 1'h0;
		@(posedge CLOCK);
		S_AXI_AWADDR <= {idx, 2'h0};
		S_AXI_WDATA <= {24'h0, d};
		S_AXI_WSTRB <= {3'h0, s};
		S_AXI_AWVALID <= 1'h1;
		S_AXI_WVALID <= 1'h1;
		S_AXI_BREADY <= 1'h1;
		while (!(ta && tw))
		begin
			@(negedge CLOCK);
			ta = ta || (S_AXI_AWVALID && S_AXI_AWREADY);
			tw = tw || (S_AXI_WVALID && S_AXI_WREADY);
			@(posedge CLOCK);
			if (ta) S_AXI_AWVALID <= 1'h0;
			if (tw) S_AXI_WVALID <= 1'h0;
		end
		do @(negedge CLOCK); while (S_AXI_BVALID !== 1'h1);
		chk(32'(S_AXI_BRESP), 32'(er));
		@(posedge CLOCK);
		S_AXI_BREADY <= 1'h0;
	endtask : wr
	task automatic rd(input logic [7:0] idx, input logic [7:0] ed,
		input logic [1:0] er = mpse_pkg::RESP_OKAY);
		@(posedge CLOCK);
		S_AXI_ARADDR <= {idx, 2'h0};
		S_AXI_ARVALID <= 1'h1;
		S_AXI_RREADY <= 1'h1;
		do @(negedge CLOCK); while (S_AXI_ARREADY !== 1'h1);
		@(posedge CLOCK);
		S_AXI_ARVALID <= 1'h0;
		do @(negedge CLOCK); while (S_AXI_RVALID !== 1'h1);
		chk(S_AXI_RDATA, {24'h0, ed});
		chk(32'(S_AXI_RRESP), 32'(er));
		@(posedge CLOCK);
		S_AXI_RREADY <= 1'h0;
	endtask : rd
	// Covers the two-flop synchroniser, the edge compare and the output register.
	task automatic settle();
		repeat (5) @(posedge CLOCK);
		@(negedge CLOCK);
	endtask : settle
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		@(negedge CLOCK);
		chk_pins(P7_PIN_OUT, 16'h0000);
		chk(32'(P7_PULLUP_EN), 32'hFF);
		chk_pins(P8_PIN_OUT, 16'h0000);
		chk(32'(NMI_INPUT_N), 32'h1);
		rd(mpse_pkg::IDX_P7_LATCH, 8'hFF);
		rd(mpse_pkg::IDX_P8_LATCH, 8'hFF);
		rd(mpse_pkg::IDX_P7_DIR, 8'h00);
		rd(8'h30, 8'h00, mpse_pkg::RESP_SLVERR);
		wr(8'h30, 8'h5A, 1'h1, mpse_pkg::RESP_SLVERR);
	endtask : t_reset
	task automatic t_port7();
		wr(mpse_pkg::IDX_P7_DIR, 8'h0F);
		wr(mpse_pkg::IDX_P7_LATCH, 8'hA5);
		wr(mpse_pkg::IDX_P7_LATCH, 8'h00, 1'h0);
		p7_ext_en <= 8'h50;
		p7_ext_val <= 8'h10;
		settle();
		chk_pins(P7_PIN_OUT, 16'h050F);
		chk(32'(P7_PULLUP_EN), 32'hA0);
		rd(mpse_pkg::IDX_P7_LATCH, 8'hB5);
		p7_ext_en <= 8'h00;
	endtask : t_port7
	task automatic t_clkout();
		TIMER_FLIPFLOP_OUTPUT_A <= 1'h1;
		wr(mpse_pkg::IDX_P7_DIR, 8'h4C);
		wr(mpse_pkg::IDX_P7_LATCH, 8'h00);
		wr(mpse_pkg::IDX_P7_FUNC, 8'h44);
		wr(mpse_pkg::IDX_CLKOUT_CTRL, 8'h01);
		settle();
		chk_pins(P7_PIN_OUT, 16'h0C4C);
		wr(mpse_pkg::IDX_CLKOUT_CTRL, 8'h03);
		settle();
		chk_pins(P7_PIN_OUT, 16'h044C);
		wr(mpse_pkg::IDX_P7_DIR, 8'h44);
		settle();
		chk_pins(P7_PIN_OUT, 16'h0444);
		wr(mpse_pkg::IDX_CLKOUT_CTRL, 8'h00);
		wr(mpse_pkg::IDX_P7_DIR, 8'h08);
		settle();
		chk_pins(P7_PIN_OUT, 16'h0008);
	endtask : t_clkout
	task automatic t_nmi();
		@(posedge CLOCK);
		p7_ext_en <= 8'h80;
		wr(mpse_pkg::IDX_P7_DIR, 8'h80);
		wr(mpse_pkg::IDX_P7_FUNC, 8'h80);
		settle();
		chk({P7_PIN_OUT.drive_en[7], NMI_INPUT_N}, 32'h0);
		wr(mpse_pkg::IDX_P7_FUNC, 8'h00);
		settle();
		chk({P7_PIN_OUT.drive_en[7], NMI_INPUT_N}, 32'h0);
		@(posedge CLOCK);
		NRST <= 1'h0;
		@(negedge CLOCK);
		chk(32'(P7_PULLUP_EN), 32'hFF);
		repeat (2) @(posedge CLOCK);
		NRST <= 1'h1;
		p7_ext_en <= 8'h00;
		settle();
		chk(32'(NMI_INPUT_N), 32'h1);
		wr(mpse_pkg::IDX_P7_DIR, 8'h80);
		settle();
		chk(32'(P7_PIN_OUT.drive_en[7]), 32'h1);
	endtask : t_nmi
	task automatic pulses(input int k, output int ni, output int nt);
		ni = 0;
		nt = 0;
		repeat (8)
		begin
			@(negedge CLOCK);
			ni += int'(SHARED_EVENTS.irq_edge[k] === 1'h1);
			nt += int'(SHARED_EVENTS.timer_event[k] === 1'h1);
		end
	endtask : pulses
	task automatic t_events();
		int pin[4] = '{0, 1, 4, 5};
		int ni;
		int nt;
		wr(mpse_pkg::IDX_P7_DIR, 8'h00);
		p7_ext_val <= 8'h00;
		p7_ext_en <= 8'h33;
		for (int e = 1; e >= 0; e--)
		begin
			wr(mpse_pkg::IDX_ALT_IN_CTRL, (e == 1) ? 8'hFF : 8'h00);
			settle();
			foreach (pin[k])
				repeat (2)
				begin
					@(posedge CLOCK);
					p7_ext_val[pin[k]] <= ~p7_ext_val[pin[k]];
					pulses(k, ni, nt);
					chk(32'(ni), 32'(e));
					chk(32'(nt), 32'(e));
				end
		end
		@(posedge CLOCK);
		p7_ext_en <= 8'h00;
	endtask : t_events
	// Each word: direction, latch, open-drain enable, function.
	function automatic logic [15:0] p8_exp(input logic [31:0] c);
		logic [7:0] v;
		logic [7:0] o;
		v = c[23:16];
		o = (c[15:8] & 8'h3F) | 8'hC0;
		if (c[0]) v[0] = 1'h0;
		if (c[3]) v[3] = 1'h1;
		p8_exp = {v & ~o & c[31:24], c[31:24] & (~o | ~v)};
	endfunction : p8_exp
	task automatic t_port8();
		logic [31:0] cfg[3] = '{32'h3F2E0500, 32'hFF36FF09, 32'hC0400000};
		@(posedge CLOCK);
		p8_ext_en <= 8'h16;
		p8_ext_val <= 8'h04;
		SERIAL_ZERO_RX_PIN <= 1'h0;
		settle();
		chk({SERIAL_ONE_RECEIVE, BYTE_TIMER_EVENT_INPUT, BUS_WAIT_REQ_N}, 32'h2);
		chk(32'(SERIAL_ZERO_RECEIVE), 32'h0);
		@(posedge CLOCK);
		p8_ext_en <= 8'h00;
		foreach (cfg[i])
		begin
			wr(mpse_pkg::IDX_P8_DIR, cfg[i][31:24]);
			wr(mpse_pkg::IDX_P8_LATCH, cfg[i][23:16]);
			wr(mpse_pkg::IDX_P8_ODEN, cfg[i][15:8]);
			wr(mpse_pkg::IDX_P8_FUNC, cfg[i][7:0]);
			settle();
			chk_pins(P8_PIN_OUT, p8_exp(cfg[i]));
			rd(mpse_pkg::IDX_P8_LATCH, (cfg[i][31:24] & cfg[i][23:16]) | ~cfg[i][31:24]);
		end
	endtask : t_port8

	initial
	begin
		repeat (12) @(posedge CLOCK);
		NRST <= 1'h1;
		repeat (4) @(posedge CLOCK);
		t_reset();
		t_port7();
		t_clkout();
		t_nmi();
		t_events();
		t_port8();
		conclude();
	end
endmodule : mpse_port78_tb_top
